// file: pps_regs.sv
// Function
// - LED blank bit drives all port LED pins high; clear restores indication.
// - Transmit-disable bit holds the port transmitter off.
// - Writing one to negotiation restart bit restarts auto-negotiation.
// - Port 1 far-end fault disable stops detection and fault pattern sending.
// - Power-down bit puts the port PHY into power down; resets zero.
// - Crossover-off bit disables auto crossover; port 2 resets from strap.
// - Force-straight selects MDI when crossover off, else MDI-X; port 2 strap.
// - Loopback bit loops opposite port receive traffic back out its transmit.
// - Link status bit 7 shows MDI-X (one) or MDI (zero).
// - Link status bit 6 shows negotiation completed.
// - Link status bit 5 shows link good.
// - Link status bits 4..0 show partner pause, 100F, 100H, 10F, 10H.
// - Operating status bit 7 is writable algorithm select, resets one, all three ports.
// - Operating status bit 5 shows reversed receive polarity on PHY ports.
// - Operating status bits 4 and 3 show transmit and receive flow control.
// - Operating status bit 2 shows 100 megabit speed.
// - Operating status bit 1 shows full duplex.
// - Operating status bit 0 shows far-end fault on port 1 only.
// - Port 3 has no link status register; only operating status.
// - Control registers sit at 0x1D for port 1 and 0x2D for port 2.
//
// Local design decision: the APB interface to the registers.
module pps_regs (
  input wire logic CLK,
  input wire logic SRST,
  // APB slave port.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [pps_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Port 2 crossover straps, sampled while reset is held.
  input wire logic PORT2_CROSSOVER_OFF_STRAP,
  input wire logic PORT2_FORCE_STRAIGHT_STRAP,
  // Live PHY and MAC state.
  input wire pps_pkg::pps_phy_status_t P1_STATUS,
  input wire pps_pkg::pps_phy_status_t P2_STATUS,
  input wire logic P3_TX_FLOW_ACTIVE,
  input wire logic P3_RX_FLOW_ACTIVE,
  input wire logic P3_SPEED_100,
  input wire logic P3_FULL_DUPLEX,
  // Normal LED indication from the port logic, four pins per port.
  input wire logic [3:0] P1_LED_NORMAL,
  input wire logic [3:0] P2_LED_NORMAL,
  // Controls towards the PHYs.
  output logic [3:0] P1_PORT_LED_PINS,
  output logic [3:0] P2_PORT_LED_PINS,
  output logic P1_TX_DISABLE,
  output logic P2_TX_DISABLE,
  output logic P1_AN_RESTART,
  output logic P2_AN_RESTART,
  output logic P1_FEF_ENABLE,
  output logic P1_POWER_DOWN,
  output logic P2_POWER_DOWN,
  output logic P1_AUTO_CROSSOVER,
  output logic P2_AUTO_CROSSOVER,
  output logic P1_FORCE_STRAIGHT,
  output logic P2_FORCE_STRAIGHT,
  output logic P1_LOOPBACK,
  output logic P2_LOOPBACK,
  output logic P1_CROSSOVER_ALGORITHM_SELECT,
  output logic P2_CROSSOVER_ALGORITHM_SELECT
);
  import pps_pkg::*;

  pps_reg_if rif ();

  logic [7:0] p1_ctrl_reg;
  logic [7:0] p2_ctrl_reg;
  logic p1_algo_reg;
  logic p2_algo_reg;
  logic p3_algo_reg;
  logic p1_restart_reg;
  logic p2_restart_reg;
  logic strap_xoff_reg;
  logic strap_fstr_reg;
  logic in_reset_reg;
  logic [7:0] rdata_mux;
  logic hit_mux;
  logic wr_p1_ctrl;
  logic wr_p2_ctrl;

  // Builds the link status byte of a PHY port.
  function automatic logic [7:0] link_byte(input pps_phy_status_t s);
    link_byte = {s.crossover_mdix, s.negotiation_complete_flag, s.link_good, s.partner_ability};
  endfunction

  // Builds the operating status byte; reserved bit 6 reads zero.
  function automatic logic [7:0] oper_byte(input logic algo, input logic pol, input logic txfc, input logic rxfc,
                                           input logic spd, input logic dpx, input logic fef);
    oper_byte = {algo, 1'b0, pol, txfc, rxfc, spd, dpx, fef};
  endfunction

  // ==========================================================
  // Bus slave.
  // ==========================================================
  pps_apb_slave u_apb (
    .clk(CLK),
    .srst(SRST),
    .psel(PSEL),
    .penable(PENABLE),
    .pwrite(PWRITE),
    .paddr(PADDR),
    .pwdata(PWDATA),
    .pstrb(PSTRB),
    .prdata(PRDATA),
    .pready(PREADY),
    .pslverr(PSLVERR),
    .rif(rif.slave)
  );

  // ==========================================================
  // Address decode and read mux.
  // ==========================================================
  // Reads are pure muxing of live state, so they disturb nothing.
  always_comb begin
    rdata_mux = 8'h00;
    hit_mux = 1'b1;
    unique case (rif.index)
      P1_CTRL_IDX: rdata_mux = p1_ctrl_reg;
      P2_CTRL_IDX: rdata_mux = p2_ctrl_reg;
      P1_LINK_IDX: rdata_mux = link_byte(P1_STATUS);
      P2_LINK_IDX: rdata_mux = link_byte(P2_STATUS);
      P3_LINK_IDX: rdata_mux = 8'h00;
      P1_OPER_IDX: rdata_mux = oper_byte(p1_algo_reg, P1_STATUS.polarity_reversed, P1_STATUS.tx_flow_active,
                                         P1_STATUS.rx_flow_active, P1_STATUS.speed_100, P1_STATUS.full_duplex,
                                         P1_STATUS.far_end_fault);
      P2_OPER_IDX: rdata_mux = oper_byte(p2_algo_reg, P2_STATUS.polarity_reversed, P2_STATUS.tx_flow_active,
                                         P2_STATUS.rx_flow_active, P2_STATUS.speed_100, P2_STATUS.full_duplex,
                                         1'b0);
      P3_OPER_IDX: rdata_mux = oper_byte(p3_algo_reg, 1'b0, P3_TX_FLOW_ACTIVE, P3_RX_FLOW_ACTIVE, P3_SPEED_100,
                                         P3_FULL_DUPLEX, 1'b0);
      default: hit_mux = 1'b0;
    endcase
  end

  assign rif.rdata = rdata_mux;
  assign rif.hit = hit_mux;
  assign wr_p1_ctrl = rif.wr_en && (rif.index == P1_CTRL_IDX);
  assign wr_p2_ctrl = rif.wr_en && (rif.index == P2_CTRL_IDX);

  // ==========================================================
  // Strap capture.
  // ==========================================================
  // Straps are sampled by a clocked process while reset is held.
  always_ff @(posedge CLK) begin
    in_reset_reg <= SRST;
    if (SRST) begin
      strap_xoff_reg <= PORT2_CROSSOVER_OFF_STRAP;
      strap_fstr_reg <= PORT2_FORCE_STRAIGHT_STRAP;
    end
  end

  // ==========================================================
  // Control registers.
  // ==========================================================
  // Port 1 control; the restart bit is a command and is not stored.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      p1_ctrl_reg <= CTRL_RESET;
    end else if (wr_p1_ctrl) begin
      p1_ctrl_reg <= rif.wdata & ~(8'h01 << CTL_AN_RESTART);
    end
  end

  // Port 2 control; crossover bits load from the straps once reset ends.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      p2_ctrl_reg <= CTRL_RESET;
    end else if (in_reset_reg) begin
      p2_ctrl_reg[CTL_XOVER_OFF] <= strap_xoff_reg;
      p2_ctrl_reg[CTL_FORCE_STRAIGHT] <= strap_fstr_reg;
    end else if (wr_p2_ctrl) begin
      p2_ctrl_reg <= rif.wdata & ~((8'h01 << CTL_AN_RESTART) | (8'h01 << CTL_FEF_OFF));
    end
  end

  // Negotiation restart requests as one-cycle pulses.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      p1_restart_reg <= 1'b0;
      p2_restart_reg <= 1'b0;
    end else begin
      p1_restart_reg <= wr_p1_ctrl && rif.wdata[CTL_AN_RESTART];
      p2_restart_reg <= wr_p2_ctrl && rif.wdata[CTL_AN_RESTART];
    end
  end

  // Algorithm select bits of the operating status registers.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      p1_algo_reg <= ALGO_SEL_RESET;
      p2_algo_reg <= ALGO_SEL_RESET;
      p3_algo_reg <= ALGO_SEL_RESET;
    end else if (rif.wr_en) begin
      if (rif.index == P1_OPER_IDX) begin
        p1_algo_reg <= rif.wdata[OPS_ALGO_SEL];
      end
      if (rif.index == P2_OPER_IDX) begin
        p2_algo_reg <= rif.wdata[OPS_ALGO_SEL];
      end
      if (rif.index == P3_OPER_IDX) begin
        p3_algo_reg <= rif.wdata[OPS_ALGO_SEL];
      end
    end
  end

  // ==========================================================
  // Outputs towards the PHYs.
  // ==========================================================
  // LED pins go high while blanked, else follow normal indication.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      P1_PORT_LED_PINS <= 4'h0;
      P2_PORT_LED_PINS <= 4'h0;
    end else begin
      P1_PORT_LED_PINS <= p1_ctrl_reg[CTL_LED_BLANK] ? 4'hf : P1_LED_NORMAL;
      P2_PORT_LED_PINS <= p2_ctrl_reg[CTL_LED_BLANK] ? 4'hf : P2_LED_NORMAL;
    end
  end

  // Controls decoded straight from the control, restart pulse and algorithm select registers.
  assign P1_TX_DISABLE = p1_ctrl_reg[CTL_TX_OFF];
  assign P2_TX_DISABLE = p2_ctrl_reg[CTL_TX_OFF];
  assign P1_AN_RESTART = p1_restart_reg;
  assign P2_AN_RESTART = p2_restart_reg;
  assign P1_FEF_ENABLE = ~p1_ctrl_reg[CTL_FEF_OFF];
  assign P1_POWER_DOWN = p1_ctrl_reg[CTL_PWR_DOWN];
  assign P2_POWER_DOWN = p2_ctrl_reg[CTL_PWR_DOWN];
  assign P1_AUTO_CROSSOVER = ~p1_ctrl_reg[CTL_XOVER_OFF];
  assign P2_AUTO_CROSSOVER = ~p2_ctrl_reg[CTL_XOVER_OFF];
  assign P1_FORCE_STRAIGHT = p1_ctrl_reg[CTL_XOVER_OFF] & p1_ctrl_reg[CTL_FORCE_STRAIGHT];
  assign P2_FORCE_STRAIGHT = p2_ctrl_reg[CTL_XOVER_OFF] & p2_ctrl_reg[CTL_FORCE_STRAIGHT];
  assign P1_LOOPBACK = p1_ctrl_reg[CTL_LOOPBACK];
  assign P2_LOOPBACK = p2_ctrl_reg[CTL_LOOPBACK];
  assign P1_CROSSOVER_ALGORITHM_SELECT = p1_algo_reg;
  assign P2_CROSSOVER_ALGORITHM_SELECT = p2_algo_reg;
endmodule : pps_regs

// file: pps_pkg.sv
package pps_pkg;
  // ==========================================================
  // Register indices and address width.
  // ==========================================================
  localparam logic [7:0] P1_CTRL_IDX = 8'h1d;
  localparam logic [7:0] P1_LINK_IDX = 8'h1e;
  localparam logic [7:0] P1_OPER_IDX = 8'h1f;
  localparam logic [7:0] P2_CTRL_IDX = 8'h2d;
  localparam logic [7:0] P2_LINK_IDX = 8'h2e;
  localparam logic [7:0] P2_OPER_IDX = 8'h2f;
  localparam logic [7:0] P3_LINK_IDX = 8'h3e;
  localparam logic [7:0] P3_OPER_IDX = 8'h3f;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;

  // ==========================================================
  // Control register field positions.
  // ==========================================================
  localparam int CTL_LED_BLANK = 7;
  localparam int CTL_TX_OFF = 6;
  localparam int CTL_AN_RESTART = 5;
  localparam int CTL_FEF_OFF = 4;
  localparam int CTL_PWR_DOWN = 3;
  localparam int CTL_XOVER_OFF = 2;
  localparam int CTL_FORCE_STRAIGHT = 1;
  localparam int CTL_LOOPBACK = 0;

  // ==========================================================
  // Operating status field positions and reset values.
  // ==========================================================
  localparam int OPS_ALGO_SEL = 7;
  localparam int OPS_RSVD = 6;
  localparam int OPS_POL_REV = 5;
  localparam int OPS_TX_FC = 4;
  localparam int OPS_RX_FC = 3;
  localparam int OPS_SPEED = 2;
  localparam int OPS_DUPLEX = 1;
  localparam int OPS_FEF = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic ALGO_SEL_RESET = 1'b1;
  localparam logic [7:0] LINK_ST_RESET = 8'h00;

  // Live status of one PHY port as seen by the register bank.
  typedef struct packed {
    logic crossover_mdix;
    logic negotiation_complete_flag;
    logic link_good;
    logic [4:0] partner_ability;
    logic polarity_reversed;
    logic tx_flow_active;
    logic rx_flow_active;
    logic speed_100;
    logic full_duplex;
    logic far_end_fault;
  } pps_phy_status_t;

  // Bus access state encoding.
  typedef enum logic [1:0] {
    PPS_ST_IDLE = 2'b00,
    PPS_ST_ACCESS = 2'b01
  } pps_bus_state_t;
endpackage : pps_pkg

// file: pps_reg_if.sv
// Register access carrier between the bus slave and the register bank.
interface pps_reg_if;
  import pps_pkg::*;
  logic wr_en;
  logic rd_en;
  logic [7:0] index;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic hit;
  modport slave (output wr_en, output rd_en, output index, output wdata, input rdata, input hit);
  modport bank (input wr_en, input rd_en, input index, input wdata, output rdata, output hit);
endinterface : pps_reg_if

// file: pps_apb_slave.sv
// ==========================================================
// APB slave: one-wait-free access, registered read data.
// ==========================================================
module pps_apb_slave (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pps_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  pps_reg_if.slave rif
);
  import pps_pkg::*;

  logic setup;
  logic aligned;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic ack_reg;

  // Setup phase sampled; access ends one cycle later.
  assign setup = psel && !penable;
  assign aligned = (paddr[1:0] == 2'b00);
  assign rif.index = paddr[9:2];
  assign rif.wdata = pwdata[7:0];
  assign rif.wr_en = psel && penable && ack_reg && pwrite && pstrb[0] && rif.hit && aligned;
  assign rif.rd_en = setup && !pwrite;

  // Answer comes in the first access cycle after the setup.
  always_ff @(posedge clk) begin
    if (srst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= setup;
    end
  end

  // Read data and error are captured during setup.
  always_ff @(posedge clk) begin
    if (srst) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (setup) begin
      prdata_reg <= (rif.rd_en && rif.hit && aligned) ? {24'h00_0000, rif.rdata} : 32'h0000_0000;
      pslverr_reg <= !(rif.hit && aligned);
    end
  end

  assign pready = psel && penable && ack_reg;
  assign prdata = prdata_reg;
  assign pslverr = pready && pslverr_reg;
endmodule : pps_apb_slave

// file: pps_regs_checker.sv
// ======================================
// Port control and status checker.
// ======================================
module pps_regs_checker (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [pps_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire pps_pkg::pps_phy_status_t P1_STATUS,
  input wire logic [3:0] P1_PORT_LED_PINS,
  input wire logic P1_TX_DISABLE,
  input wire logic P1_AN_RESTART,
  input wire logic P1_FEF_ENABLE,
  input wire logic P2_POWER_DOWN,
  input wire logic P1_AUTO_CROSSOVER,
  input wire logic P1_FORCE_STRAIGHT,
  input wire logic P2_LOOPBACK
);
  timeunit 1ns;
  timeprecision 1ps;
  import pps_pkg::*;
  logic acc;
  logic wr1;
  logic wr2;
  // Completed accesses and completed writes to the two control registers.
  assign acc = PSEL && PENABLE && PREADY;
  assign wr1 = acc && PWRITE && PSTRB[0] && PADDR == 10'h074;
  assign wr2 = acc && PWRITE && PSTRB[0] && PADDR == 10'h0b4;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  a_led_blank: assert property (wr1 && PWDATA[7] |-> ##[1:2] (P1_PORT_LED_PINS == 4'hf))
    else $error("LED pins not blanked after blank write");
  a_tx_off: assert property (wr1 |=> P1_TX_DISABLE == $past(PWDATA[6]))
    else $error("Transmit disable does not follow control write");
  a_restart_pulse: assert property (P1_AN_RESTART |-> $past(wr1 && PWDATA[5]) ##1 !P1_AN_RESTART)
    else $error("Negotiation restart pulse without cause or too long");
  a_fault_enable: assert property (wr1 |=> P1_FEF_ENABLE != $past(PWDATA[4]))
    else $error("Far-end fault enable wrong after control write");
  a_power_down: assert property (wr2 |=> P2_POWER_DOWN == $past(PWDATA[3]))
    else $error("Power down does not follow control write");
  a_crossover_mode: assert property (wr1 |=> P1_AUTO_CROSSOVER != $past(PWDATA[2]) &&
    P1_FORCE_STRAIGHT == ($past(PWDATA[2]) && $past(PWDATA[1])))
    else $error("Crossover controls wrong after control write");
  a_loop_back: assert property (wr2 |=> P2_LOOPBACK == $past(PWDATA[0]))
    else $error("Loopback does not follow control write");
  a_link_live: assert property (PSEL && PENABLE && !PWRITE && PADDR == 10'h078 |->
    PRDATA == {24'h00_0000, $past(P1_STATUS[13:6])})
    else $error("Link status read does not show live state");
  a_ready_nowait: assert property (PSEL && !PENABLE ##1 PSEL && PENABLE |-> PREADY)
    else $error("Access phase not answered at once");
  a_bad_addr: assert property (acc && PADDR[1:0] != 2'h0 |-> PSLVERR)
    else $error("Misaligned access not refused");
endmodule // pps_regs_checker

// file: pps_phy_model.sv
// ======================================
// Live PHY and MAC state source.
// ======================================
module pps_phy_model (
  input wire logic [13:0] pat,
  output pps_pkg::pps_phy_status_t p1_status,
  output pps_pkg::pps_phy_status_t p2_status,
  output logic [3:0] p3_flags,
  output logic [3:0] led_normal
);
  timeunit 1ns;
  timeprecision 1ps;
  import pps_pkg::*;
  // Port 2 shows the inverse so each bit differs between the ports.
  assign p1_status = pat;
  assign p2_status = ~pat;
  assign p3_flags = pat[4:1];
  assign led_normal = pat[3:0];
endmodule // pps_phy_model

// file: tb_phy_port_control_status_regs.sv
// ======================================
// Register bank testbench.
// ======================================
module tb_phy_port_control_status_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import pps_pkg::*;
  logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, s_off = 1'b1, s_fs = 1'b1;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic [3:0] pstrb = 4'hf, p3f, lnorm, led1, led2;
  logic [13:0] pat = 14'h0000;
  logic [13:0] pats [2] = '{14'h2b4d, 14'h14b2};
  logic pready, pslverr, e, txd1, txd2, an1, an2, fef1, pd1, pd2, ax1, ax2, fs1, fs2, lb1, lb2, al1, al2;
  logic [10:0] p1v;
  logic [9:0] p2v;
  pps_phy_status_t p1s, p2s;
  int err_total = 0, tests_run = 0;
  // Control outputs gathered per port for comparison.
  assign p1v = {led1, txd1, fef1, pd1, ax1, fs1, lb1, al1};
  assign p2v = {led2, txd2, pd2, ax2, fs2, lb2, al2};
  // Free running clock.
  always #2 clk = ~clk;
  pps_phy_model u_pps_phy_model (.pat(pat), .p1_status(p1s), .p2_status(p2s), .p3_flags(p3f), .led_normal(lnorm));
  pps_regs u_pps_regs (.CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PORT2_CROSSOVER_OFF_STRAP(s_off), .PORT2_FORCE_STRAIGHT_STRAP(s_fs), .P1_STATUS(p1s), .P2_STATUS(p2s),
    .P3_TX_FLOW_ACTIVE(p3f[3]), .P3_RX_FLOW_ACTIVE(p3f[2]), .P3_SPEED_100(p3f[1]), .P3_FULL_DUPLEX(p3f[0]),
    .P1_LED_NORMAL(lnorm), .P2_LED_NORMAL(lnorm), .P1_PORT_LED_PINS(led1), .P2_PORT_LED_PINS(led2),
    .P1_TX_DISABLE(txd1), .P2_TX_DISABLE(txd2), .P1_AN_RESTART(an1), .P2_AN_RESTART(an2), .P1_FEF_ENABLE(fef1),
    .P1_POWER_DOWN(pd1), .P2_POWER_DOWN(pd2), .P1_AUTO_CROSSOVER(ax1), .P2_AUTO_CROSSOVER(ax2),
    .P1_FORCE_STRAIGHT(fs1), .P2_FORCE_STRAIGHT(fs2), .P1_LOOPBACK(lb1), .P2_LOOPBACK(lb2),
    .P1_CROSSOVER_ALGORITHM_SELECT(al1), .P2_CROSSOVER_ALGORITHM_SELECT(al2));
  // Compares one value and counts it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // One APB transfer: setup, access held until ready, then release.
  task automatic apb(input logic [9:0] a, input logic w, input logic [7:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      err_total++;
      end_of_test();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Reads a register and compares its byte.
  task automatic rd(input logic [9:0] a, input logic [7:0] x);
    apb(a, 1'b0, 8'h00);
    chk(q, {24'h00_0000, x});
  endtask
  // Main sequence.
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rd(10'h074, 8'h00); // Port 1 control at reset.
    rd(10'h0b4, 8'h06); // Port 2 control from straps.
    rd(10'h07c, 8'h80); // Algorithm select resets one.
    rd(10'h078, 8'h00); // Link status at reset.
    chk(32'(p1v), 32'h0000_0029); // Port 1 pins at reset.
    chk(32'(p2v), 32'h0000_0005); // Port 2 pins from straps.
    $display("Test reset done");
    foreach (pats[i]) begin
      pat <= pats[i];
      rd(10'h078, pats[i][13:6]); // Port 1 link status.
      rd(10'h07c, {2'h2, pats[i][5:0]}); // Port 1 operating status.
      rd(10'h0b8, ~pats[i][13:6]); // Port 2 link status.
      rd(10'h0bc, {2'h2, ~pats[i][5:1], 1'b0}); // Port 2 has no fault bit.
      rd(10'h0fc, {3'h4, pats[i][4:1], 1'b0}); // Port 3 operating status.
      rd(10'h0f8, 8'h00); // Port 3 link slot is empty.
    end
    apb(10'h078, 1'b1, 8'hff);
    rd(10'h078, pats[1][13:6]); // Read-only link status kept.
    $display("Test status done");
    apb(10'h074, 1'b1, 8'hff);
    @(negedge clk);
    chk(32'(an1), 32'h0000_0001); // Port 1 restart pulse after the write.
    rd(10'h074, 8'hdf); // Restart bit clears itself.
    repeat (2) @(posedge clk);
    chk(32'(p1v), 32'h0000_07d7); // All port 1 controls on.
    chk(32'(an1), 32'h0000_0000); // Restart is a single pulse.
    apb(10'h074, 1'b1, 8'h04);
    repeat (2) @(posedge clk);
    chk(32'(p1v), 32'h0000_0121); // Normal LEDs and crossover mode.
    apb(10'h0b4, 1'b1, 8'hff);
    @(negedge clk);
    chk(32'(an2), 32'h0000_0001); // Port 2 restart pulse after the write.
    rd(10'h0b4, 8'hcf); // Port 2 fault and restart bits read zero.
    repeat (2) @(posedge clk);
    chk(32'(p2v), 32'h0000_03f7); // Port 2 controls on.
    chk(32'(an2), 32'h0000_0000); // Restart is a single pulse.
    apb(10'h0b4, 1'b1, 8'h00);
    repeat (2) @(posedge clk);
    chk(32'(p2v), 32'h0000_0089); // Port 2 controls off.
    $display("Test control done");
    apb(10'h07c, 1'b1, 8'h3f); // Reserved bit 6 left at zero.
    apb(10'h0bc, 1'b1, 8'h00); // Port 2 algorithm select cleared, bit 6 zero.
    rd(10'h07c, {2'h0, pats[1][5:0]}); // Algorithm select cleared, reserved bit kept.
    chk(32'(al1), 32'h0000_0000); // Algorithm select pin follows.
    chk(32'(al2), 32'h0000_0000); // Port 2 algorithm select pin follows.
    apb(10'h000, 1'b0, 8'h00);
    chk({q[30:0], e}, 32'h0000_0001); // Unmapped read refused.
    apb(10'h075, 1'b1, 8'hff);
    chk(32'(e), 32'h0000_0001); // Misaligned write refused.
    pstrb <= 4'h0;
    apb(10'h074, 1'b1, 8'hff);
    pstrb <= 4'hf;
    rd(10'h074, 8'h04); // Control untouched by refused writes.
    $display("Test access done");
    end_of_test();
  end
endmodule // tb_phy_port_control_status_regs

bind pps_regs pps_regs_checker u_pps_regs_checker (.CLK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB,
  .PRDATA, .PREADY, .PSLVERR, .P1_STATUS, .P1_PORT_LED_PINS, .P1_TX_DISABLE, .P1_AN_RESTART, .P1_FEF_ENABLE,
  .P2_POWER_DOWN, .P1_AUTO_CROSSOVER, .P1_FORCE_STRAIGHT, .P2_LOOPBACK);
